// file: src/dcr_config_regs.sv
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_config_regs
  import dcr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire dcr_cmd_t    cmd,
  input  wire logic        flashModeTx,
  input  wire logic        activeMode,
  input  wire logic        standbyActive,
  input  wire logic        loadCurrentLow,
  input  wire dcr_fault_t  fault,
  input  wire logic [3:0]  clusterOverTemp,
  output logic [23:0]      readData,
  output logic             readValid,
  output logic [15:0]      matchPayload,
  output dcr_mode_t        mode,
  output logic             watchdogEnable,
  output logic             watchdogSetupWriteAllow,
  output logic             watchdogStandbyOff,
  output logic             pumpRun,
  output dcr_status_t      status,
  output logic [3:0]       stageOff
);

  dcr_state_t st_reg;
  dcr_state_t st_next;

  function automatic logic hit(input dcr_cmd_t c, input logic [5:0] a);
    hit = c.valid && (c.addr == a);
  endfunction

  function automatic logic [23:0] readBack(input dcr_state_t s, input logic [5:0] a);
    readBack = 24'h000000;
    unique case (a)
      `DCR_ADDR_WAKE_DATA:
      begin
        readBack[`DCR_POS_BYTE7_LO +: 8] = s.matchPayloadSeventh;
        readBack[`DCR_POS_BYTE8_LO +: 8] = s.matchPayloadEighth;
      end
      `DCR_ADDR_PUMP_CTRL:
      begin
        readBack[`DCR_POS_PUMP_OFF] = s.pumpDisable;
        readBack[`DCR_POS_LOAD_CURRENT_SUPERVISION_DISABLE_OFF] = s.loadSupervisionDisable;
        readBack[`DCR_POS_WATCHDOG_ENABLE_BIT]    = s.watchdogEnable;
      end
      `DCR_ADDR_DEV_CFG:
      begin
        readBack[`DCR_POS_WAKE_PIN]   = s.mode.wakePinMeasure;
        readBack[`DCR_POS_LIN_WAKE]   = s.mode.linWakeOnEdge;
        readBack[`DCR_POS_LIN_FAST]   = s.mode.linFastRate;
        readBack[`DCR_POS_TSD_POLICY] = s.mode.thermalSelective;
        readBack[`DCR_POS_EC_HV]      = s.mode.electrochromeHigh;
        readBack[`DCR_POS_DUAL_MOTOR] = s.mode.dualMotor;
        readBack[`DCR_POS_LOAD_CURRENT_SUPERVISION_DISABLE_UNLK]  = s.loadSupervisionUnlock;
        readBack[`DCR_POS_WD_UNLK]    = s.watchdogSetupUnlock;
        readBack[`DCR_POS_MASK_HS1 -: 4] = s.masks;
        readBack[`DCR_POS_PUMP_UNLK]  = s.pumpDisableUnlock;
      end
      default:
      begin
        readBack = 24'h000000;
      end
    endcase
  endfunction

  logic wrWake;
  logic wrPump;
  logic wrCfg;

  always_comb
  begin
    wrWake  = hit(cmd, `DCR_ADDR_WAKE_DATA) && cmd.write;
    wrPump  = hit(cmd, `DCR_ADDR_PUMP_CTRL) && cmd.write;
    wrCfg   = hit(cmd, `DCR_ADDR_DEV_CFG) && cmd.write;
    st_next = st_reg;

    // Read data is the value before this command's write
    st_next.readValid = cmd.valid;
    if (cmd.valid)
    begin
      st_next.readData = readBack(st_reg, cmd.addr);
    end

    if (wrWake)
    begin
      st_next.matchPayloadSeventh = cmd.wdata[`DCR_POS_BYTE7_LO +: 8];
      st_next.matchPayloadEighth  = cmd.wdata[`DCR_POS_BYTE8_LO +: 8];
    end

    if (wrPump)
    begin
      if (!cmd.wdata[`DCR_POS_PUMP_OFF] || st_reg.pumpDisableUnlock)
      begin
        st_next.pumpDisable = cmd.wdata[`DCR_POS_PUMP_OFF];
      end
      if (!cmd.wdata[`DCR_POS_LOAD_CURRENT_SUPERVISION_DISABLE_OFF] || st_reg.loadSupervisionUnlock)
      begin
        st_next.loadSupervisionDisable = cmd.wdata[`DCR_POS_LOAD_CURRENT_SUPERVISION_DISABLE_OFF];
      end
      if (flashModeTx)
      begin
        st_next.watchdogEnable = cmd.wdata[`DCR_POS_WATCHDOG_ENABLE_BIT];
      end
    end

    // Any command consumes the unlocks; a config write may re-arm them.
    // supervision, watchdog setup and pump unlocks are one-shot
    if (cmd.valid)
    begin
      st_next.loadSupervisionUnlock = wrCfg && cmd.wdata[`DCR_POS_LOAD_CURRENT_SUPERVISION_DISABLE_UNLK];
      st_next.watchdogSetupUnlock   = wrCfg && cmd.wdata[`DCR_POS_WD_UNLK];
      st_next.pumpDisableUnlock     = wrCfg && cmd.wdata[`DCR_POS_PUMP_UNLK];
    end

    if (wrCfg)
    begin
      st_next.mode.wakePinMeasure    = cmd.wdata[`DCR_POS_WAKE_PIN];
      st_next.mode.linWakeOnEdge     = cmd.wdata[`DCR_POS_LIN_WAKE];
      st_next.mode.linFastRate       = cmd.wdata[`DCR_POS_LIN_FAST];
      st_next.mode.thermalSelective  = cmd.wdata[`DCR_POS_TSD_POLICY];
      st_next.mode.electrochromeHigh = cmd.wdata[`DCR_POS_EC_HV];
      st_next.mode.dualMotor         = cmd.wdata[`DCR_POS_DUAL_MOTOR];
      st_next.masks                  = cmd.wdata[`DCR_POS_MASK_HS1 -: 4];
    end

    st_next.pumpRun = activeMode && !st_reg.pumpDisable;

    st_next.watchdogStandbyOff = standbyActive &&
                                 (st_reg.loadSupervisionDisable || loadCurrentLow);

    st_next.stageOff = st_reg.mode.thermalSelective ? clusterOverTemp
                                                     : {4{|clusterOverTemp}};

    st_next.status.functionalError = fault.openLoadHs1 || fault.openLoadLs1 ||
                                     fault.openLoadEc || fault.otherOpenLoad;
    st_next.status.globalWarning   = fault.thermalWarning;
    st_next.status.globalError = (fault.openLoadHs1 && !st_reg.masks[3]) ||
                                 (fault.openLoadLs1 && !st_reg.masks[2]) ||
                                 (fault.thermalWarning && !st_reg.masks[1]) ||
                                 (fault.openLoadEc && !st_reg.masks[0]) ||
                                 fault.otherOpenLoad || fault.otherError;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_reg                     <= '0;
      st_reg.watchdogEnable      <= `DCR_RST_WATCHDOG_ENABLE_BIT;
      st_reg.mode.wakePinMeasure <= `DCR_RST_WAKE_PIN;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs are flops of the state record, nothing combinational
  assign readData                = st_reg.readData;
  assign readValid               = st_reg.readValid;
  assign matchPayload            = {st_reg.matchPayloadEighth, st_reg.matchPayloadSeventh};
  assign mode                    = st_reg.mode;
  assign watchdogEnable          = st_reg.watchdogEnable;
  assign watchdogSetupWriteAllow = st_reg.watchdogSetupUnlock;
  assign watchdogStandbyOff      = st_reg.watchdogStandbyOff;
  assign pumpRun                 = st_reg.pumpRun;
  assign status                  = st_reg.status;
  assign stageOff                = st_reg.stageOff;

endmodule

// file: pkg/dcr_defines.svh
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

`define DCR_ADDR_W          6
`define DCR_DATA_W          24
`define DCR_CLUSTERS        4

`define DCR_ADDR_WAKE_DATA  6'h1d
`define DCR_ADDR_PUMP_CTRL  6'h22
`define DCR_ADDR_DEV_CFG    6'h3f

`define DCR_POS_BYTE7_LO    0
`define DCR_POS_BYTE8_LO    8

`define DCR_POS_PUMP_OFF    2
`define DCR_POS_LOAD_CURRENT_SUPERVISION_DISABLE_OFF    1
`define DCR_POS_WATCHDOG_ENABLE_BIT       0

`define DCR_POS_WAKE_PIN    23
`define DCR_POS_LIN_WAKE    22
`define DCR_POS_LIN_FAST    21
`define DCR_POS_TSD_POLICY  20
`define DCR_POS_EC_HV       19
`define DCR_POS_DUAL_MOTOR  18
`define DCR_POS_LOAD_CURRENT_SUPERVISION_DISABLE_UNLK   17
`define DCR_POS_WD_UNLK     16
`define DCR_POS_MASK_HS1    15
`define DCR_POS_MASK_LS1    14
`define DCR_POS_MASK_THERMAL_WARNING     13
`define DCR_POS_MASK_EC     12
`define DCR_POS_PUMP_UNLK   7

`define DCR_RST_WATCHDOG_ENABLE_BIT       1'h1
`define DCR_RST_WAKE_PIN    1'h1
`define DCR_RST_OTHER       1'h0

`endif

// file: pkg/dcr_pkg.sv
package dcr_pkg;
  `include "dcr_defines.svh"

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [5:0] addr;
    logic [23:0] wdata;
  } dcr_cmd_t;

  typedef struct packed {
    logic wakePinMeasure;
    logic linWakeOnEdge;
    logic linFastRate;
    logic thermalSelective;
    logic electrochromeHigh;
    logic dualMotor;
  } dcr_mode_t;

  typedef struct packed {
    logic functionalError;
    logic globalWarning;
    logic globalError;
  } dcr_status_t;

  typedef struct packed {
    logic openLoadHs1;
    logic openLoadLs1;
    logic thermalWarning;
    logic openLoadEc;
    logic otherOpenLoad;
    logic otherError;
  } dcr_fault_t;

  typedef struct packed {
    logic [7:0]  matchPayloadSeventh;
    logic [7:0]  matchPayloadEighth;
    logic        pumpDisable;
    logic        loadSupervisionDisable;
    logic        watchdogEnable;
    dcr_mode_t   mode;
    logic        loadSupervisionUnlock;
    logic        watchdogSetupUnlock;
    logic        pumpDisableUnlock;
    logic [3:0]  masks;
    logic [23:0] readData;
    logic        readValid;
    dcr_status_t status;
    logic        pumpRun;
    logic        watchdogStandbyOff;
    logic [3:0]  stageOff;
  } dcr_state_t;
endpackage

// file: sim/dcr_config_regs_properties.sv
`timescale 1ns/1ps
module dcr_config_regs_properties
  import dcr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire dcr_cmd_t    cmd,
  input wire logic        flashModeTx,
  input wire logic        activeMode,
  input wire logic        standbyActive,
  input wire logic        loadCurrentLow,
  input wire logic [15:0] matchPayload,
  input wire dcr_mode_t   mode,
  input wire logic        watchdogEnable,
  input wire logic        watchdogSetupWriteAllow,
  input wire logic        watchdogStandbyOff,
  input wire logic        pumpRun
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wrCfg;
    cmd.valid && cmd.write && cmd.addr == 6'h3f;
  endsequence
  sequence wrPump;
    cmd.valid && cmd.write && cmd.addr == 6'h22;
  endsequence
  chk_payload_store: assert property (cmd.valid && cmd.write && cmd.addr == 6'h1d
    |=> matchPayload == $past(cmd.wdata[15:0])) else $error("payload bytes");
  chk_mode_store: assert property (wrCfg |=> mode == $past(cmd.wdata[23:18]))
    else $error("mode bits");
  chk_payload_hold: assert property (!(cmd.valid && cmd.write && cmd.addr == 6'h1d)
    |=> $stable(matchPayload)) else $error("payload bytes moved");
  chk_mode_hold: assert property (!(cmd.valid && cmd.write && cmd.addr == 6'h3f)
    |=> $stable(mode)) else $error("mode bits moved");
  chk_wd_unlock_set: assert property (wrCfg ##0 cmd.wdata[16] |=> watchdogSetupWriteAllow)
    else $error("unlock not armed");
  chk_wd_unlock_drop: assert property (cmd.valid && !(cmd.write && cmd.addr == 6'h3f
    && cmd.wdata[16]) |=> !watchdogSetupWriteAllow) else $error("unlock kept");
  chk_wd_enable_lock: assert property (wrPump ##0 !flashModeTx |=> $stable(watchdogEnable))
    else $error("watchdog enable written");
  chk_pump_idle: assert property (!activeMode |=> !pumpRun)
    else $error("pump runs");
  chk_standby_low: assert property (standbyActive && loadCurrentLow |=> watchdogStandbyOff)
    else $error("standby off missing");
  chk_standby_none: assert property (!standbyActive |=> !watchdogStandbyOff)
    else $error("standby off stray");
endmodule
bind dcr_config_regs dcr_config_regs_properties u_chk (.sys_clk(sys_clk), .rst(rst),
  .cmd(cmd), .flashModeTx(flashModeTx), .activeMode(activeMode),
  .standbyActive(standbyActive), .loadCurrentLow(loadCurrentLow), .mode(mode),
  .matchPayload(matchPayload), .watchdogEnable(watchdogEnable), .pumpRun(pumpRun),
  .watchdogSetupWriteAllow(watchdogSetupWriteAllow), .watchdogStandbyOff(watchdogStandbyOff));

// file: sim/dcr_host_model.sv
`timescale 1ns/1ps
module dcr_host_model
  import dcr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        readValid,
  input  wire logic [23:0] readData,
  output dcr_cmd_t         cmd
);
  initial cmd = '0;
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [23:0] d,
                      output logic [23:0] q, output logic ok);
    @(posedge sys_clk);
    cmd <= {1'b1, wr, a, d};
    @(posedge sys_clk);
    // Idle bus shows inverted leftovers, never a stale copy
    cmd <= {1'b0, ~wr, ~a, ~d};
    #1;
    ok = readValid === 1'b1;
    q = readData;
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import dcr_pkg::*;
;
  logic        sys_clk, rst, flashModeTx, activeMode, standbyActive, loadCurrentLow, ok;
  logic        readValid, watchdogEnable, watchdogSetupWriteAllow, watchdogStandbyOff, pumpRun;
  logic [3:0]  clusterOverTemp, stageOff;
  logic [15:0] matchPayload;
  logic [23:0] readData, m1d, m22, m3f, exp, q;
  logic [5:0]  tbl [4] = '{6'h1d, 6'h22, 6'h3f, 6'h10};
  dcr_cmd_t    cmd;
  dcr_fault_t  fault;
  dcr_mode_t   mode;
  dcr_status_t status;
  int          bad_count, num_checks, seed, i;
  dcr_config_regs u_dcr_config_regs (.sys_clk(sys_clk), .rst(rst), .cmd(cmd),
    .flashModeTx(flashModeTx), .activeMode(activeMode), .standbyActive(standbyActive),
    .loadCurrentLow(loadCurrentLow), .fault(fault), .clusterOverTemp(clusterOverTemp),
    .readData(readData), .readValid(readValid), .matchPayload(matchPayload), .mode(mode),
    .watchdogEnable(watchdogEnable), .watchdogSetupWriteAllow(watchdogSetupWriteAllow),
    .watchdogStandbyOff(watchdogStandbyOff), .pumpRun(pumpRun), .status(status),
    .stageOff(stageOff));
  dcr_host_model u_dcr_host_model (.sys_clk(sys_clk), .readValid(readValid),
    .readData(readData), .cmd(cmd));
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    num_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic op(input logic wr, input logic [5:0] a, input logic [23:0] d);
    exp = a == 6'h1d ? m1d : a == 6'h22 ? m22 : a == 6'h3f ? m3f : 24'h0;
    u_dcr_host_model.xfer(wr, a, d, q, ok);
    check({23'h0, ok}, 24'h1);
    if (!ok)
      report_and_stop();
    check(q, exp);
    if (wr && a == 6'h1d)
      m1d = d & 24'h00ffff;
    if (wr && a == 6'h22)
    begin
      if (!d[2] || m3f[7])
        m22[2] = d[2];
      if (!d[1] || m3f[17])
        m22[1] = d[1];
      if (flashModeTx)
        m22[0] = d[0];
    end
    m3f &= 24'hfcff7f;
    if (wr && a == 6'h3f)
      m3f = d & 24'hfff080;
    check({23'h0, watchdogSetupWriteAllow}, {23'h0, m3f[16]});
    check({18'h0, mode}, {18'h0, m3f[23:18]});
    check({8'h0, matchPayload}, m1d);
    check({23'h0, watchdogEnable}, {23'h0, m22[0]});
    @(posedge sys_clk);
    #1;
    check({23'h0, pumpRun}, {23'h0, activeMode & ~m22[2]});
    check({23'h0, watchdogStandbyOff}, {23'h0, standbyActive & (m22[1] | loadCurrentLow)});
    exp = {22'h0, fault.thermalWarning, |(fault & ~{m3f[15:12], 2'b0})};
    check({22'h0, status[1:0]}, exp);
    exp = {23'h0, fault.openLoadHs1 | fault.openLoadLs1 | fault.openLoadEc | fault.otherOpenLoad};
    check({23'h0, status[2]}, exp);
    check({23'h0, readValid}, 24'h0);
    check({20'h0, stageOff}, {20'h0, m3f[20] ? clusterOverTemp : {4{|clusterOverTemp}}});
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rst, flashModeTx, activeMode, standbyActive, loadCurrentLow, clusterOverTemp} = 9'h100;
    fault = '0;
    {bad_count, num_checks, seed} = {32'd0, 32'd0, 32'd30926};
    {m1d, m22, m3f} = {24'h0, 24'h1, 24'h800000};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    activeMode <= 1'b1;
    op(1'b0, 6'h22, 24'h0);
    op(1'b0, 6'h3f, 24'h0);
    op(1'b1, 6'h22, 24'h000006);
    op(1'b1, 6'h3f, 24'h830080);
    op(1'b1, 6'h22, 24'h000006);
    op(1'b1, 6'h22, 24'h000000);
    op(1'b1, 6'h3f, 24'h830080);
    op(1'b0, 6'h1d, 24'h0);
    op(1'b1, 6'h22, 24'hffffff);
    for (i = 0; i < 400; i++)
    begin
      @(posedge sys_clk);
      {flashModeTx, activeMode, standbyActive, loadCurrentLow, clusterOverTemp} <= 8'($random(seed));
      fault <= 6'($random(seed));
      op(1'($random(seed)), tbl[2'($random(seed))], 24'($random(seed)));
    end
    // Mid-run reset must bring every register back to its reset value
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    {m1d, m22, m3f} = {24'h0, 24'h1, 24'h800000};
    for (i = 0; i < 3; i++)
    begin
      op(1'b0, tbl[i], 24'h0);
    end
    report_and_stop();
  end
endmodule
